// [pkg/lpc_pkg.sv]
// lpc_pkg: constants and types for the low-power mode controller
// assumes a single 20 MHz clock domain and no register bus
package lpc_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int WAKE_TIME_NS = 10000;
  // longest wakeup time, rounded down to whole cycles
  localparam int WAKE_CYCLES = WAKE_TIME_NS / CLK_PERIOD_NS;
  // supply restore steps, each a few cycles
  localparam int SUPPLY_STEP_CYCLES = 4;
  localparam int WAKE_PIN_COUNT = 14;
  localparam int SYNC_STAGES = 3;
  localparam logic [2:0] DIVIDER_RESET = 3'h0;

  // operating states, one-hot
  typedef enum logic [5:0] {
    LPC_RUN = 6'h01,
    LPC_SLEEP = 6'h02,
    LPC_WAIT = 6'h04,
    LPC_CORE_UP = 6'h08,
    LPC_SRAM_UP = 6'h10,
    LPC_RESUME = 6'h20
  } lpc_state_t;

  // kind of low-power mode entered
  typedef enum logic [1:0] {
    LPC_MODE_NONE = 2'h0,
    LPC_MODE_WAIT_DPD = 2'h1,
    LPC_MODE_WAIT_STBY = 2'h2,
    LPC_MODE_SLEEP = 2'h3
  } lpc_mode_t;
endpackage : lpc_pkg

// [src/lpc_sync.sv]
// lpc_sync: three-stage synchroniser for pin-level inputs, a change is
// seen once the second and third stages agree
// assumes the input is asynchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module lpc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  // accept a value only when the later stages agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      assign next_level[g] = (stage2[g] == stage3[g]) ? stage3[g] : level_o[g];
    end
  endgenerate

  // shift chain
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level_o <= '0;
    end
    else
    begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
      level_o <= next_level;
    end
  end
endmodule : lpc_sync
`default_nettype wire

// [src/lpc_ctrl.sv]
// lpc_ctrl: low-power mode selection, wakeup collection and supply restore
// assumes mode settings and cpu signals come from logic on clk_i; wake pins
// and remote wake events arrive asynchronously
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - wait with flash deep power-down on settings
// - wait with flash standby when flash bit clear
// - sleep on wait-for-interrupt, interrupt wakes
// - wait wakes on pins, alarms, usb, debug, ethernet
// - wait wakeup below ten microseconds
// - resume on rc oscillator, pll left off
// - debug power-up request ends wait mode
// - sleep stops core clock, peripherals may run
// - wakeup restores core and sram supplies
module lpc_ctrl #(
  parameter int WAKE_PINS = lpc_pkg::WAKE_PIN_COUNT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] master_clock_divider_i,
  input wire logic wait_mode_request_i,
  input wire logic deep_sleep_select_i,
  input wire logic low_power_select_i,
  input wire logic flash_low_power_select_i,
  input wire logic wait_for_interrupt_i,
  input wire logic interrupt_pending_i,
  input wire logic [WAKE_PINS-1:0] wakeup_pins_i,
  input wire logic rtc_alarm_i,
  input wire logic real_time_timer_alarm_i,
  input wire logic high_speed_usb_wake_i,
  input wire logic debug_power_up_request_i,
  input wire logic ethernet_wake_i,
  input wire logic core_supply_on_i,
  input wire logic sram_supply_on_i,
  output logic core_clock_en_o,
  output logic periph_clock_keep_o,
  output logic flash_deep_power_down_o,
  output logic flash_standby_o,
  output logic core_supply_en_o,
  output logic sram_supply_en_o,
  output logic rc_osc_select_o,
  output logic pll_enable_o,
  output logic io_hold_o,
  output logic [1:0] mode_o,
  output logic wakeup_o,
  output logic fetch_release_o
);
  localparam int SRC_W = WAKE_PINS + 5;
  lpc_pkg::lpc_state_t state, next_state;
  lpc_pkg::lpc_mode_t mode;
  logic [SRC_W-1:0] src_level;
  logic [7:0] step_cnt;
  logic [15:0] wake_cnt;

  // remote sources all pass the three-stage synchroniser
  lpc_sync #(
    .WIDTH(SRC_W)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({wakeup_pins_i, rtc_alarm_i, real_time_timer_alarm_i,
              high_speed_usb_wake_i, debug_power_up_request_i, ethernet_wake_i}),
    .level_o(src_level)
  );

  // mode decode from the settings
  wire base_ok = (master_clock_divider_i == lpc_pkg::DIVIDER_RESET) && wait_mode_request_i
                 && !deep_sleep_select_i && low_power_select_i;
  wire enter_wait_dpd = base_ok && flash_low_power_select_i;
  wire enter_wait_stby = base_ok && !flash_low_power_select_i;
  wire enter_sleep = wait_for_interrupt_i && !deep_sleep_select_i && !low_power_select_i;
  // any wait wake source; can shares the pins
  wire wait_wake = |src_level;
  // debug request alone also ends wait
  wire debug_wake = src_level[1];
  wire in_wait = (state == lpc_pkg::LPC_WAIT);

  // next-state selection
  always_comb
  begin
    next_state = state;
    case (state)
      lpc_pkg::LPC_RUN:
        if (enter_wait_dpd || enter_wait_stby)
          next_state = lpc_pkg::LPC_WAIT;
        else if (enter_sleep)
          next_state = lpc_pkg::LPC_SLEEP;
      lpc_pkg::LPC_SLEEP:
        if (interrupt_pending_i)
          next_state = lpc_pkg::LPC_RUN;
      lpc_pkg::LPC_WAIT:
        if (wait_wake || debug_wake)
          next_state = lpc_pkg::LPC_CORE_UP;
      lpc_pkg::LPC_CORE_UP:
        if (core_supply_on_i && step_cnt == 8'h00)
          next_state = lpc_pkg::LPC_SRAM_UP;
      lpc_pkg::LPC_SRAM_UP:
        if (sram_supply_on_i && step_cnt == 8'h00)
          next_state = lpc_pkg::LPC_RESUME;
      lpc_pkg::LPC_RESUME:
        next_state = lpc_pkg::LPC_RUN;
      default:
        next_state = lpc_pkg::LPC_RUN;
    endcase
  end

  // state, mode and counters
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= lpc_pkg::LPC_RUN;
      mode <= lpc_pkg::LPC_MODE_NONE;
      step_cnt <= 8'h00;
      wake_cnt <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      if (state == lpc_pkg::LPC_RUN && next_state == lpc_pkg::LPC_WAIT)
        mode <= enter_wait_dpd ? lpc_pkg::LPC_MODE_WAIT_DPD : lpc_pkg::LPC_MODE_WAIT_STBY;
      else if (state == lpc_pkg::LPC_RUN && next_state == lpc_pkg::LPC_SLEEP)
        mode <= lpc_pkg::LPC_MODE_SLEEP;
      else if (next_state == lpc_pkg::LPC_RUN)
        mode <= lpc_pkg::LPC_MODE_NONE;
      if (next_state != state)
        step_cnt <= 8'(lpc_pkg::SUPPLY_STEP_CYCLES - 1);
      else if (step_cnt != 8'h00)
        step_cnt <= step_cnt - 8'h01;
      if (in_wait)
        wake_cnt <= 16'h0000;
      else if (wake_cnt != 16'hffff)
        wake_cnt <= wake_cnt + 16'h0001;
    end
  end

  // registered outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      core_clock_en_o <= 1'b1;
      periph_clock_keep_o <= 1'b0;
      flash_deep_power_down_o <= 1'b0;
      flash_standby_o <= 1'b0;
      core_supply_en_o <= 1'b1;
      sram_supply_en_o <= 1'b1;
      rc_osc_select_o <= 1'b0;
      pll_enable_o <= 1'b1;
      io_hold_o <= 1'b0;
      mode_o <= 2'h0;
      wakeup_o <= 1'b0;
      fetch_release_o <= 1'b1;
    end
    else
    begin
      // core clock stops in sleep and wait, peripherals kept in sleep
      core_clock_en_o <= (next_state == lpc_pkg::LPC_RUN);
      periph_clock_keep_o <= (next_state == lpc_pkg::LPC_SLEEP);
      flash_deep_power_down_o <= (next_state == lpc_pkg::LPC_WAIT) &&
        (in_wait ? mode == lpc_pkg::LPC_MODE_WAIT_DPD : enter_wait_dpd);
      flash_standby_o <= (next_state == lpc_pkg::LPC_WAIT) &&
        (in_wait ? mode == lpc_pkg::LPC_MODE_WAIT_STBY : !enter_wait_dpd);
      core_supply_en_o <= core_supply_en_o || (next_state == lpc_pkg::LPC_CORE_UP);
      sram_supply_en_o <= sram_supply_en_o || (next_state == lpc_pkg::LPC_SRAM_UP);
      // rc oscillator selected and pll off from wait entry, both held until reset
      if (next_state == lpc_pkg::LPC_WAIT)
        rc_osc_select_o <= 1'b1;
      if (next_state == lpc_pkg::LPC_WAIT)
        pll_enable_o <= 1'b0;
      io_hold_o <= (next_state != lpc_pkg::LPC_RUN);
      mode_o <= (next_state == lpc_pkg::LPC_RUN) ? 2'h0 : mode;
      wakeup_o <= (state == lpc_pkg::LPC_WAIT) && (next_state == lpc_pkg::LPC_CORE_UP);
      fetch_release_o <= (next_state == lpc_pkg::LPC_RUN);
    end
  end

  wake_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == lpc_pkg::LPC_RESUME) |-> (wake_cnt < 16'(lpc_pkg::WAKE_CYCLES)))
    else $error("wakeup too slow");
  dpd_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == lpc_pkg::LPC_RUN && enter_wait_dpd) |=> flash_deep_power_down_o && !core_clock_en_o)
    else $error("dpd wait not entered");
  stby_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == lpc_pkg::LPC_RUN && enter_wait_stby) |=> flash_standby_o && !flash_deep_power_down_o)
    else $error("standby wait not entered");
  sleep_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == lpc_pkg::LPC_SLEEP && interrupt_pending_i) |=> core_clock_en_o)
    else $error("sleep did not wake");
  wait_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_wait && wait_wake) |=> wakeup_o ##[1:40] fetch_release_o)
    else $error("wait wake lost");
  debug_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_wait && debug_wake) |=> state == lpc_pkg::LPC_CORE_UP)
    else $error("debug wake ignored");
  pll_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(fetch_release_o) && rc_osc_select_o |-> !pll_enable_o)
    else $error("pll restarted");
  sleep_clk_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == lpc_pkg::LPC_SLEEP) |-> !core_clock_en_o && periph_clock_keep_o)
    else $error("sleep clocks wrong");
  supply_up_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == lpc_pkg::LPC_RESUME) |-> core_supply_en_o && sram_supply_en_o)
    else $error("supply not restored");
  io_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state != lpc_pkg::LPC_RUN) |-> io_hold_o)
    else $error("pins not held");

  cover_dpd_c: cover property (@(posedge clk_i) in_wait && mode == lpc_pkg::LPC_MODE_WAIT_DPD);
  cover_stby_c: cover property (@(posedge clk_i) in_wait && mode == lpc_pkg::LPC_MODE_WAIT_STBY);
  cover_sleep_c: cover property (@(posedge clk_i) state == lpc_pkg::LPC_SLEEP ##1 core_clock_en_o);
  cover_wake_c: cover property (@(posedge clk_i) wakeup_o);
endmodule : lpc_ctrl
`default_nettype wire

// [verif/lpc_wake_model.sv]
// lpc_wake_model: far-side wake sources and supply-good feedback
// assumes the bench picks a source number and holds its request as a level
`timescale 1ns/1ps
`default_nettype none
module lpc_wake_model #(
  parameter int CAN_PIN = 5
) (
  input wire logic clk_i,
  input wire logic [4:0] sel_i,
  input wire logic req_i,
  input wire logic core_en_i,
  input wire logic sram_en_i,
  output logic [13:0] pins_o,
  output logic [4:0] remote_o,
  output logic core_on_o,
  output logic sram_on_o
);
  logic [19:0] hit;
  // one line per source, all low while idle
  assign hit = req_i ? (20'h00001 << sel_i) : 20'h00000;
  assign remote_o = hit[18:14];
  assign pins_o = hit[13:0] | (hit[19] ? (14'h0001 << CAN_PIN) : 14'h0000);
  // supply good one cycle after enable
  always_ff @(posedge clk_i)
  begin
    core_on_o <= core_en_i;
    sram_on_o <= sram_en_i;
  end
endmodule : lpc_wake_model
`default_nettype wire

// [verif/tb_top.sv]
// tb_top: random and directed mode entry and wakeup checks for lpc_ctrl
// assumes one 20 MHz clock; inputs driven on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] div;
  logic wreq, deep, lp, flp, halt, irq, req;
  logic [4:0] sel, remote;
  logic [13:0] pins;
  logic cclk, pkeep, fdpd, fstby, cen, sen, rc, pll, hold, wake, fetch, con, son;
  logic [1:0] mode;
  int num_errors = 0;
  int cmp_count = 0;
  int seed = 10601;
  lpc_ctrl u_lpc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .master_clock_divider_i(div),
    .wait_mode_request_i(wreq), .deep_sleep_select_i(deep), .low_power_select_i(lp),
    .flash_low_power_select_i(flp), .wait_for_interrupt_i(halt), .interrupt_pending_i(irq),
    .wakeup_pins_i(pins), .rtc_alarm_i(remote[0]), .real_time_timer_alarm_i(remote[1]),
    .high_speed_usb_wake_i(remote[2]), .debug_power_up_request_i(remote[3]),
    .ethernet_wake_i(remote[4]), .core_supply_on_i(con), .sram_supply_on_i(son),
    .core_clock_en_o(cclk), .periph_clock_keep_o(pkeep), .flash_deep_power_down_o(fdpd),
    .flash_standby_o(fstby), .core_supply_en_o(cen), .sram_supply_en_o(sen),
    .rc_osc_select_o(rc), .pll_enable_o(pll), .io_hold_o(hold), .mode_o(mode),
    .wakeup_o(wake), .fetch_release_o(fetch));
  lpc_wake_model u_lpc_wake_model (.clk_i(clk_i), .sel_i(sel), .req_i(req),
    .core_en_i(cen), .sram_en_i(sen), .pins_o(pins), .remote_o(remote),
    .core_on_o(con), .sram_on_o(son));
  // free-running clock
  always #25 clk_i = ~clk_i;
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // mode expected from the entry settings
  function automatic logic [1:0] exp_mode(input logic [2:0] d, input logic [4:0] s);
    if (d == 3'h0 && s[4] && !s[3] && s[2])
      return s[1] ? 2'h1 : 2'h2;
    if (s[0] && !s[3] && !s[2])
      return 2'h3;
    return 2'h0;
  endfunction : exp_mode
  task automatic finish_test();
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  // s: wait, deep, lp, flash, halt
  task automatic enter(input logic [2:0] d, input logic [4:0] s, output logic [1:0] m);
    m = exp_mode(d, s);
    @(negedge clk_i);
    {wreq, deep, lp, flp, halt} = s;
    div = d;
    @(negedge clk_i);
    {wreq, deep, lp, flp, halt} = 5'h00;
    div = 3'h0;
    check("flash_dpd", fdpd, m == 2'h1);
    check("flash_stby", fstby, m == 2'h2);
    check("core_clk", cclk, m == 2'h0);
    check("periph_clk", pkeep, m == 2'h3);
    check("io_hold", hold, m != 2'h0);
    // mode status follows the latched mode one cycle after entry
    @(negedge clk_i);
    check("mode", mode, m);
  endtask : enter
  // source 0..19 for wait, 20 is the sleep interrupt
  task automatic wake_up(input logic [4:0] s);
    int n;
    logic pulse;
    n = 0;
    pulse = 1'b0;
    repeat ($unsigned($random(seed)) % 16) @(negedge clk_i);
    if (s == 5'd20)
      irq = 1'b1;
    else
    begin
      sel = s;
      req = 1'b1;
    end
    while (fetch !== 1'b1 && n < 400)
    begin
      @(negedge clk_i);
      n++;
      pulse = pulse | (wake === 1'b1);
    end
    check("in_time", n <= lpc_pkg::WAKE_CYCLES, 8'h01);
    check("wake_pulse", pulse, s != 5'd20);
    check("mode_run", mode, 8'h00);
    check("io_hold", hold, 8'h00);
    check("supplies", {cen, sen}, 8'h03);
    // software side may now restore its clock setup
    check("core_clk_back", cclk, 8'h01);
    if (s != 5'd20)
      check("rc_pll", {rc, pll}, 8'h02);
    req = 1'b0;
    irq = 1'b0;
    repeat (8) @(negedge clk_i);
  endtask : wake_up
  initial
  begin
    logic [1:0] m;
    {div, wreq, deep, lp, flp, halt, irq, req, sel} = 15'h0000;
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    check("reset_out", {cclk, pll, rc, hold, fetch, mode}, 8'h64);
    // every wait wake source, flash variant at random
    for (int s = 0; s < 20; s++)
    begin
      enter(3'h0, {3'h5, 1'($random(seed)), 1'b0}, m);
      wake_up(5'(s));
    end
    // random settings, refusals included
    for (int k = 0; k < 24; k++)
    begin
      enter(3'($random(seed)), 5'($random(seed)), m);
      if (m == 2'h3)
        wake_up(5'd20);
      else if (m != 2'h0)
        wake_up(5'($unsigned($random(seed)) % 20));
    end
    enter(3'h0, 5'h01, m);
    wake_up(5'd20);
    finish_test();
  end
  // watchdog against a hang
  initial
  begin
    #(lpc_pkg::CLK_PERIOD_NS * 20000);
    num_errors++;
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
